/* logic/sse_defs.svh */
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

// Timing
`define SSE_CLK_PERIOD_NS         4
`define SSE_WRITE_CYCLE_NS        5000000
`define SSE_WRITE_CYCLES          (`SSE_WRITE_CYCLE_NS / `SSE_CLK_PERIOD_NS)

// Array geometry
`define SSE_ADDR_W                9
`define SSE_PAGE_W                3
`define SSE_PAGE_BYTES            8

// Opcode fields
`define SSE_OP_HI_NIBBLE          4'h0
`define SSE_SET_WRITE_LATCH_OP    3'h6
`define SSE_CLEAR_WRITE_LATCH_OP  3'h4
`define SSE_STATUS_READ_OP        3'h5
`define SSE_STATUS_WRITE_OP       3'h1
`define SSE_ARRAY_READ_OP         3'h3
`define SSE_ARRAY_WRITE_OP        3'h2

// Status register fields and values
`define SSE_STAT_BUSY_BIT         0
`define SSE_STAT_WEL_BIT          1
`define SSE_STAT_BP_LO_BIT        2
`define SSE_STAT_BP_HI_BIT        3
`define SSE_STAT_SPARE_VAL        4'h0
`define SSE_STAT_BUSY_VAL         8'hFF
`define SSE_BP_RESET              2'h0
`define SSE_WEL_RESET             1'b0

// Protected region bases
`define SSE_PROT_QUARTER_BASE     9'h180
`define SSE_PROT_HALF_BASE        9'h100

// Synchronised pin reset: cs_n, sck, si, hold_n, wp_n
`define SSE_PINS_RESET            5'h13

`endif

/* logic/sse_pkg.sv */
`default_nettype none
package sse_pkg;

    typedef enum logic [2:0] {
        SSE_ST_IDLE      = 3'h0,
        SSE_ST_OPCODE    = 3'h1,
        SSE_ST_ADDR      = 3'h3,
        SSE_ST_DATA_RD   = 3'h2,
        SSE_ST_DATA_WR   = 3'h6,
        SSE_ST_STATUS_RD = 3'h7,
        SSE_ST_STATUS_WR = 3'h5,
        SSE_ST_IGNORE    = 3'h4
    } sse_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } sse_pins_t;

    typedef struct packed {
        logic [3:0] spare;
        logic       protect_level_hi;
        logic       protect_level_lo;
        logic       wel;
        logic       busy;
    } sse_status_t;

endpackage
`default_nettype wire

/* logic/sse_sync.sv */
`default_nettype none
module sse_sync #(
    parameter int             W       = 5,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // System
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule
`default_nettype wire

/* logic/sse_wr_timer.sv */
`default_nettype none
module sse_wr_timer #(
    parameter int CYCLES = 1250000,
    parameter int CNT_W  = $clog2(CYCLES + 1)
) (
    // System
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             busy_reg;
    logic             busy_next;

    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        if (start && !busy_reg) begin
            cnt_next  = LOAD;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_next = 1'b0;
            end else begin
                cnt_next = cnt_reg - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
        end
    end

    assign busy = busy_reg;
    assign done = busy_reg && (cnt_reg == '0);

endmodule
`default_nettype wire

/* logic/sse_slave.sv */
// Functional notes
// R1: First byte is opcode, carries address bit nine
// R2: Bad opcode: ignore input, output off
// R3: Deselected: ignore input, output high impedance
// R4: Pause keeps state, output off, input ignored
// R5: Write protect low blocks all writes
// R6: Protect during select aborts; programming unaffected
// R7: Decode set, clear latch and status read
// R8: Decode status write, array read, array write
// R9: Write latch clear at power-up
// R10: Master holds protect high for latch set
// R11: Clear latch works regardless of protect
// R12: Status: busy, latch, two protect bits
// R13: Upper bits zero; all ones while busy
// R14: Protect levels: none, quarter, half, all
// R15: Protect bits programmed like memory, show busy
// R16: Read auto-increments, wraps whole array
// R17: Programming starts at select rise after byte
// R18: Protected locations are never altered
// R19: While busy only status read accepted
// R20: Page of eight, low bits wrap
// R21: Latch clears when programming completes
// R22: Rejected write discarded, standby at deselect
// R23: Busy lasts a configurable cycle count
`include "sse_defs.svh"
`default_nettype none
module sse_slave
    import sse_pkg::*;
#(
    parameter int WRITE_CYCLES = `SSE_WRITE_CYCLES
) (
    // System
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Serial pins
    input  wire logic spi_cs_n,
    input  wire logic spi_sck,
    input  wire logic spi_si,
    input  wire logic spi_hold_n,
    input  wire logic spi_wp_n,
    output logic      spi_so,
    output logic      spi_so_oe
);

    localparam int AW = `SSE_ADDR_W;
    localparam int PW = `SSE_PAGE_W;
    localparam int PB = `SSE_PAGE_BYTES;

    function automatic logic is_protected(input logic [AW-1:0] a, input logic [1:0] lvl);
        logic hit;
        hit = 1'b0;
        case (lvl)
            2'h1: hit = (a >= `SSE_PROT_QUARTER_BASE);
            2'h2: hit = (a >= `SSE_PROT_HALF_BASE);
            2'h3: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    sse_pins_t   pins_raw;
    sse_pins_t   pins_s;
    sse_state_t  state_reg,    state_next;
    logic [2:0]  bit_cnt_reg,  bit_cnt_next;
    logic [7:0]  shin_reg,     shin_next;
    logic [7:0]  tx_reg,       tx_next;
    logic [AW-1:0] addr_reg,   addr_next;
    logic        op_rd_reg,    op_rd_next;
    logic        so_reg,       so_next;
    logic        wel_reg,      wel_next;
    logic [1:0]  bp_reg,       bp_next;
    logic        wp_abort_reg, wp_abort_next;
    logic        paused_reg,   paused_next;
    logic        sck_d_reg;
    logic        cs_d_reg;
    logic [7:0]  stat_byte_reg, stat_byte_next;
    logic        stat_got_reg,  stat_got_next;
    logic [PB-1:0] page_vld_reg, page_vld_next;
    logic [7:0]  page_reg  [PB];
    logic [7:0]  page_next [PB];
    logic [7:0]  mem       [1 << AW];

    logic        active,       wp_ok;
    logic        sck_rise,     sck_fall;
    logic        cs_fall,      cs_rise;
    logic [7:0]  rx_byte;
    logic [7:0]  tx_src;
    logic        prog_data_start, prog_stat_start;
    logic        busy,         busy_done;
    sse_status_t status_view;

    assign pins_raw = '{cs_n: spi_cs_n, sck: spi_sck, si: spi_si,
                        hold_n: spi_hold_n, wp_n: spi_wp_n};
    sse_sync #(.W(5), .RST_VAL(`SSE_PINS_RESET)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       (pins_raw),
        .q       (pins_s)
    );
    sse_wr_timer #(.CYCLES(WRITE_CYCLES)) u_timer (                                   // R23
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (prog_data_start || prog_stat_start),
        .busy    (busy),
        .done    (busy_done)
    );

    // Clock edges only count while selected and not paused
    assign active   = !pins_s.cs_n && !paused_reg;                          // R3 R4
    assign sck_rise = active && pins_s.sck && !sck_d_reg;
    assign sck_fall = active && !pins_s.sck && sck_d_reg;
    assign cs_fall  = !pins_s.cs_n && cs_d_reg;
    assign cs_rise  = pins_s.cs_n && !cs_d_reg;
    assign wp_ok    = pins_s.wp_n && !wp_abort_reg;                         // R5 R6
    assign rx_byte  = {shin_reg[6:0], pins_s.si};

    assign status_view = '{spare: `SSE_STAT_SPARE_VAL, protect_level_hi: bp_reg[1],
                           protect_level_lo: bp_reg[0], wel: wel_reg, busy: busy};  // R12
    assign tx_src = (state_reg == SSE_ST_STATUS_RD) ?
                    (busy ? `SSE_STAT_BUSY_VAL : status_view) :              // R13
                    mem[addr_reg];

    always_comb begin
        state_next      = state_reg;
        bit_cnt_next    = bit_cnt_reg;
        shin_next       = shin_reg;
        tx_next         = tx_reg;
        addr_next       = addr_reg;
        op_rd_next      = op_rd_reg;
        so_next         = so_reg;
        wel_next        = wel_reg;
        bp_next         = bp_reg;
        wp_abort_next   = wp_abort_reg;
        paused_next     = paused_reg;
        stat_byte_next  = stat_byte_reg;
        stat_got_next   = stat_got_reg;
        page_vld_next   = page_vld_reg;
        page_next       = page_reg;
        prog_data_start = 1'b0;
        prog_stat_start = 1'b0;
        if (pins_s.cs_n) begin
            state_next   = SSE_ST_IDLE;                                     // R3 R22
            bit_cnt_next = 3'h0;
            paused_next  = 1'b0;
        end else if (!pins_s.sck) begin
            paused_next  = !pins_s.hold_n;                                  // R4
        end
        if (cs_fall) begin
            state_next    = SSE_ST_OPCODE;                                  // R1 R2
            bit_cnt_next  = 3'h0;
            wp_abort_next = !pins_s.wp_n;
            page_vld_next = '0;
            stat_got_next = 1'b0;
        end else if (!pins_s.cs_n && !pins_s.wp_n) begin
            wp_abort_next = 1'b1;                                           // R6
        end
        // Programming only after whole bytes and a valid enable
        if (cs_rise && bit_cnt_reg == 3'h0 && wel_reg && wp_ok && !busy) begin   // R17 R22
            if (state_reg == SSE_ST_DATA_WR && page_vld_reg != '0) begin
                prog_data_start = 1'b1;                                     // R17
            end
            if (state_reg == SSE_ST_STATUS_WR && stat_got_reg) begin
                prog_stat_start = 1'b1;                                     // R15
                bp_next = {stat_byte_reg[`SSE_STAT_BP_HI_BIT],
                           stat_byte_reg[`SSE_STAT_BP_LO_BIT]};
            end
        end
        if (sck_rise && state_reg != SSE_ST_IGNORE && state_reg != SSE_ST_IDLE) begin  // R2
            shin_next    = rx_byte;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                case (state_reg)
                    SSE_ST_OPCODE: begin
                        state_next = SSE_ST_IGNORE;
                        if (rx_byte[7:4] != `SSE_OP_HI_NIBBLE) begin
                            state_next = SSE_ST_IGNORE;                     // R2
                        end else if (busy) begin
                            if (rx_byte[2:0] == `SSE_STATUS_READ_OP) begin  // R19
                                state_next = SSE_ST_STATUS_RD;
                            end
                        end else if (rx_byte[2:0] == `SSE_SET_WRITE_LATCH_OP) begin  // R7
                            wel_next = pins_s.wp_n;                         // R10
                        end else if (rx_byte[2:0] == `SSE_CLEAR_WRITE_LATCH_OP) begin
                            wel_next = 1'b0;                                // R11
                        end else if (rx_byte[2:0] == `SSE_STATUS_READ_OP) begin
                            state_next = SSE_ST_STATUS_RD;
                        end else if (rx_byte[2:0] == `SSE_STATUS_WRITE_OP) begin  // R8
                            state_next = SSE_ST_STATUS_WR;
                        end else if (rx_byte[2:0] == `SSE_ARRAY_READ_OP ||
                                     rx_byte[2:0] == `SSE_ARRAY_WRITE_OP) begin
                            state_next = SSE_ST_ADDR;
                            op_rd_next = rx_byte[0];
                            addr_next  = {rx_byte[3], addr_reg[AW-2:0]};    // R1
                        end
                    end
                    SSE_ST_ADDR: begin
                        addr_next  = {addr_reg[AW-1], rx_byte};
                        state_next = op_rd_reg ? SSE_ST_DATA_RD : SSE_ST_DATA_WR;
                    end
                    SSE_ST_DATA_RD: begin
                        addr_next = addr_reg + AW'(1);                      // R16
                    end
                    SSE_ST_DATA_WR: begin
                        page_next[addr_reg[PW-1:0]]     = rx_byte;          // R20
                        page_vld_next[addr_reg[PW-1:0]] = 1'b1;
                        addr_next = {addr_reg[AW-1:PW], addr_reg[PW-1:0] + PW'(1)};
                    end
                    SSE_ST_STATUS_WR: begin
                        stat_byte_next = rx_byte;
                        stat_got_next  = 1'b1;
                    end
                    default: begin
                        state_next = state_reg;
                    end
                endcase
            end
        end
        // Output shifts on the falling clock, first bit loads the byte
        if (sck_fall && (state_reg == SSE_ST_DATA_RD || state_reg == SSE_ST_STATUS_RD)) begin
            if (bit_cnt_reg == 3'h0) begin
                so_next = tx_src[7];                                        // R16
                tx_next = {tx_src[6:0], 1'b0};
            end else begin
                so_next = tx_reg[7];
                tx_next = {tx_reg[6:0], 1'b0};
            end
        end
        if (busy_done) begin
            wel_next = 1'b0;                                                // R21
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg     <= SSE_ST_IDLE;
            bit_cnt_reg   <= 3'h0;
            shin_reg      <= 8'h00;
            tx_reg        <= 8'h00;
            addr_reg      <= '0;
            op_rd_reg     <= 1'b0;
            so_reg        <= 1'b0;
            wel_reg       <= `SSE_WEL_RESET;                                // R9
            bp_reg        <= `SSE_BP_RESET;
            wp_abort_reg  <= 1'b0;
            paused_reg    <= 1'b0;
            sck_d_reg     <= 1'b0;
            cs_d_reg      <= 1'b1;
            stat_byte_reg <= 8'h00;
            stat_got_reg  <= 1'b0;
            page_vld_reg  <= '0;
            page_reg      <= '{default: 8'h00};
        end else begin
            state_reg     <= state_next;
            bit_cnt_reg   <= bit_cnt_next;
            shin_reg      <= shin_next;
            tx_reg        <= tx_next;
            addr_reg      <= addr_next;
            op_rd_reg     <= op_rd_next;
            so_reg        <= so_next;
            wel_reg       <= wel_next;
            bp_reg        <= bp_next;
            wp_abort_reg  <= wp_abort_next;
            paused_reg    <= paused_next;
            sck_d_reg     <= pins_s.sck;
            cs_d_reg      <= pins_s.cs_n;
            stat_byte_reg <= stat_byte_next;
            stat_got_reg  <= stat_got_next;
            page_vld_reg  <= page_vld_next;
            page_reg      <= page_next;
        end
    end

    // Page commit, skipping protected locations
    always_ff @(posedge sys_clk) begin
        if (prog_data_start) begin
            for (int i = 0; i < PB; i++) begin
                if (page_vld_reg[i] &&
                    !is_protected({addr_reg[AW-1:PW], PW'(i)}, bp_reg)) begin   // R14 R18
                    mem[{addr_reg[AW-1:PW], PW'(i)}] <= page_reg[i];
                end
            end
        end
    end

    assign spi_so    = so_reg;
    assign spi_so_oe = active &&
                       (state_reg == SSE_ST_DATA_RD || state_reg == SSE_ST_STATUS_RD);  // R2 R3

    AST_DESELECT_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)   // R3
        pins_s.cs_n |-> !spi_so_oe)
        else $error("output driven while deselected");
    AST_BAD_OP_STAYS: assert property (@(posedge sys_clk) disable iff (!rst_n)     // R2
        (state_reg == SSE_ST_IGNORE && !pins_s.cs_n) |=>
            (state_reg == SSE_ST_IGNORE && !spi_so_oe) || pins_s.cs_n)
        else $error("ignored transfer resumed");
    AST_PAUSE_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)      // R4
        paused_reg |-> !spi_so_oe && $stable(bit_cnt_reg) && $stable(addr_reg))
        else $error("pause did not freeze transfer");
    AST_BUSY_ALL_ONES: assert property (@(posedge sys_clk) disable iff (!rst_n)    // R13
        (sck_fall && busy && state_reg == SSE_ST_STATUS_RD && bit_cnt_reg == 3'h0)
            |=> so_reg && tx_reg == 8'hFE)
        else $error("status not all ones while busy");
    AST_LATCH_AUTO_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // R21
        $fell(busy) |-> !wel_reg)
        else $error("latch survived programming");
    AST_BUSY_FILTER: assert property (@(posedge sys_clk) disable iff (!rst_n)      // R19
        (busy && !busy_done && sck_rise && state_reg == SSE_ST_OPCODE &&
         bit_cnt_reg == 3'h7) |=>
            state_reg inside {SSE_ST_STATUS_RD, SSE_ST_IGNORE, SSE_ST_IDLE} &&
            $stable(wel_reg))
        else $error("opcode accepted while busy");
    AST_PROG_NEEDS_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R5 R22
        $rose(busy) |-> $past(wel_reg) && $past(pins_s.wp_n) && !$past(wp_abort_reg))
        else $error("programming without enable");
    AST_SET_NEEDS_WP: assert property (@(posedge sys_clk) disable iff (!rst_n)     // R10
        $rose(wel_reg) |-> $past(pins_s.wp_n))
        else $error("latch set with protect low");
    AST_POWERUP_CLEAR: assert property (@(posedge sys_clk)                         // R9
        !rst_n |=> !wel_reg && bp_reg == `SSE_BP_RESET)
        else $error("latch not clear after reset");
    AST_READ_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)        // R16
        (sck_rise && state_reg == SSE_ST_DATA_RD && bit_cnt_reg == 3'h7) |=>
            addr_reg == $past(addr_reg) + AW'(1))
        else $error("read address did not advance");
    AST_PAGE_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)        // R20
        (sck_rise && state_reg == SSE_ST_DATA_WR && bit_cnt_reg == 3'h7) |=>
            addr_reg[AW-1:PW] == $past(addr_reg[AW-1:PW]) &&
            addr_reg[PW-1:0] == $past(addr_reg[PW-1:0]) + PW'(1))
        else $error("page address wrong");
    AST_START_AT_DESELECT: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R17 R23
        $rose(busy) |-> $past(cs_rise) && $past(bit_cnt_reg) == 3'h0)
        else $error("programming started mid transfer");

endmodule
`default_nettype wire

/* dv/sse_spi_master.sv */
`default_nettype none
module sse_spi_master (
    // System
    input  wire logic sys_clk,
    // Pins toward the device
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    output logic      wp_n,
    input  wire logic so,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic saw_oe;

    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
        wp_n   = 1'b1;
        saw_oe = 1'b0;
    end

    // Remembers any output drive within the current select
    always @(posedge sys_clk) begin
        if (so_oe) begin
            saw_oe <= 1'b1;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic sel();
        tick(1);
        saw_oe <= 1'b0;
        cs_n   <= 1'b0;
        tick(4);
    endtask

    // Select rises in the low phase after the last bit
    task automatic desel();
        tick(4);
        cs_n <= 1'b1;
        si   <= ~si;
        tick(4);
    endtask

    // Mode 0, MSB first; reply sampled just before each rising edge
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            tick(5);
            rx[i] = so;
            sck <= 1'b1;
            tick(5);
            sck <= 1'b0;
        end
    endtask

    // Pause and resume only while the clock is low; a clock pulse inside
    task automatic hold(input logic v);
        hold_n <= v;
        tick(6);
        if (!v) begin
            sck <= 1'b1;
            tick(5);
            sck <= 1'b0;
            tick(6);
        end
    endtask

    task automatic set_wp(input logic v);
        wp_n <= v;
        tick(4);
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WCYC = 500;

    logic       sys_clk;
    logic       rst_n;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       hold_n;
    logic       wp_n;
    logic       so;
    logic       so_oe;
    int         mismatches;
    int         cmp_count;
    logic [7:0] st;
    logic [7:0] rb[$];
    logic [7:0] d[$];
    logic [7:0] bad[3] = '{8'h07, 8'h13, 8'h85};

    sse_slave #(.WRITE_CYCLES(WCYC)) uut (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .spi_cs_n   (cs_n),
        .spi_sck    (sck),
        .spi_si     (si),
        .spi_hold_n (hold_n),
        .spi_wp_n   (wp_n),
        .spi_so     (so),
        .spi_so_oe  (so_oe)
    );

    sse_spi_master m (
        .sys_clk (sys_clk),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .hold_n  (hold_n),
        .wp_n    (wp_n),
        .so      (so),
        .so_oe   (so_oe)
    );

    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        m.sel();
        m.xbyte(op, r);
        m.desel();
    endtask

    task automatic status_read_op(output logic [7:0] s);
        logic [7:0] r;
        m.sel();
        m.xbyte(8'h05, r);
        m.xbyte(8'h00, s);
        m.desel();
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        status_read_op(st);
        while (st[0] !== 1'b0 && n < 40) begin
            status_read_op(st);
            n++;
        end
        check({7'h00, st[0]}, 8'h00);
    endtask

    // Latch set, then array or status write; protect drops before byte wp_at
    task automatic wr(input logic [2:0] op, input logic [8:0] a, input logic [7:0] q[$],
                      input int wp_at);
        logic [7:0] r;
        cmd(8'h06);
        m.sel();
        m.xbyte({4'h0, a[8], op}, r);
        if (op == 3'h2) begin
            m.xbyte(a[7:0], r);
        end
        foreach (q[i]) begin
            if (i == wp_at) begin
                m.set_wp(1'b0);
            end
            m.xbyte(q[i], r);
        end
        m.desel();
        m.set_wp(1'b1);
    endtask

    task automatic rd(input logic [8:0] a, input int n, output logic [7:0] q[$]);
        logic [7:0] r;
        q = {};
        m.sel();
        m.xbyte({4'h0, a[8], 3'h3}, r);
        m.xbyte(a[7:0], r);
        repeat (n) begin
            m.xbyte(8'h00, r);
            q.push_back(r);
        end
        m.desel();
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        mismatches = 0;
        cmp_count  = 0;
        rst_n      = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        m.tick(4);
        check({7'h00, so_oe}, 8'h00);
        status_read_op(st);
        check(st, 8'h00);
        cmd(8'h0E);
        status_read_op(st);
        check(st, 8'h02);
        m.set_wp(1'b0);
        cmd(8'h04);
        m.set_wp(1'b1);
        status_read_op(st);
        check(st, 8'h00);
        m.set_wp(1'b0);
        cmd(8'h06);
        m.set_wp(1'b1);
        status_read_op(st);
        check(st, 8'h00);
        wr(3'h2, 9'h000, '{8'h5A}, -1);
        wait_ready();
        for (int i = 0; i < 10; i++) begin
            d.push_back(8'h10 + i[7:0]);
        end
        wr(3'h2, 9'h1FE, d, -1);
        status_read_op(st);
        check(st, 8'hFF);
        rd(9'h000, 0, rb);
        check({7'h00, m.saw_oe}, 8'h00);
        wait_ready();
        check(st, 8'h00);
        rd(9'h1F8, 9, rb);
        for (int k = 0; k < 8; k++) begin
            check(rb[k], 8'h12 + k[7:0]);
        end
        check(rb[8], 8'h5A);
        foreach (bad[i]) begin
            m.sel();
            m.xbyte(bad[i], st);
            m.xbyte(8'h03, st);
            m.xbyte(8'h00, st);
            m.desel();
            check({7'h00, m.saw_oe}, 8'h00);
        end
        wr(3'h2, 9'h1F8, '{8'h77, 8'h66}, 1);
        status_read_op(st);
        check(st, 8'h02);
        rd(9'h1F8, 1, rb);
        check(rb[0], 8'h12);
        wr(3'h1, 9'h000, '{8'h04}, -1);
        wait_ready();
        check(st, 8'h04);
        wr(3'h2, 9'h1F8, '{8'hAA}, -1);
        wait_ready();
        rd(9'h1F8, 1, rb);
        check(rb[0], 8'h12);
        wr(3'h2, 9'h17F, '{8'hA5}, -1);
        wait_ready();
        rd(9'h17F, 1, rb);
        check(rb[0], 8'hA5);
        m.sel();
        m.xbyte(8'h03, st);
        m.xbyte(8'h00, st);
        m.hold(1'b0);
        check({7'h00, so_oe}, 8'h00);
        m.hold(1'b1);
        m.xbyte(8'h00, st);
        m.desel();
        check(st, 8'h5A);
        end_of_test();
    end
endmodule
`default_nettype wire
